/* core/rtop_pkg.sv */
// Constants and carrier types of the receive overhead serial port
// Behaviour
// - Every overhead byte taken from the receive stream leaves bit by bit, MSB first, on the serial output.
// - The block makes the port clock itself and drives it out to the receiving logic.
// - Serial data, valid and frame marker change only where the port clock falls.
// - Valid is high in every port clock period that carries a real overhead bit.
// - The frame marker is high for eight port clock periods, exactly over the A1 byte.
package rtop_pkg;

	// Widths and counts
	localparam int unsigned BYTE_W       = 8;
	localparam int unsigned A1_MARK_BITS = 8;
	localparam int unsigned SYNC_STAGES  = 2;
	localparam int unsigned PORT_DIV     = 2;
	localparam int unsigned BIT_CNT_W    = 3;

	// Reset values
	localparam logic       PCLK_RST   = 1'b0;
	localparam logic       SER_RST    = 1'b0;
	localparam logic       VALID_RST  = 1'b0;
	localparam logic       FRAME_RST  = 1'b0;
	localparam logic       TGL_RST    = 1'b0;
	localparam logic [2:0] BIT_CNT_RST = 3'h0;

	// One overhead byte from the receive framer
	typedef struct packed {
		logic [BYTE_W-1:0] data;
		logic              a1_start;
	} rtop_byte_t;

	// The four pins of the serial port
	typedef struct packed {
		logic clk;
		logic data;
		logic valid;
		logic frame;
	} rtop_port_t;

	// Link side shifter state
	typedef enum logic {
		RTOP_IDLE,
		RTOP_SHIFT
	} rtop_state_t;

endpackage : rtop_pkg

/* core/rtop_sync.sv */
// Two flip-flop level synchroniser
module rtop_sync #(
	parameter logic RST_VAL = 1'b0
) (
	// Destination clock and reset
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	// Level
	input  wire logic d_in,
	output logic      q_out
);
	import rtop_pkg::*;

	logic meta_ff;
	logic sync_ff;

	// The first stage feeds the second and nothing else
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			meta_ff <= RST_VAL;
			sync_ff <= RST_VAL;
		end else begin
			meta_ff <= d_in;
			sync_ff <= meta_ff;
		end
	end

	assign q_out = sync_ff;

endmodule : rtop_sync

/* core/rtop_clkdiv.sv */
// Port clock divider on the link clock
module rtop_clkdiv (
	// Link clock and reset
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	// Port clock and its falling point
	output logic      pclk_out,
	output logic      fall_out
);
	import rtop_pkg::*;

	logic pclk_ff;

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			pclk_ff <= PCLK_RST;
		end else begin
			pclk_ff <= ~pclk_ff;
		end
	end

	assign pclk_out = pclk_ff;
	// High in the link cycle whose closing edge drops the port clock
	assign fall_out = pclk_ff;

endmodule : rtop_clkdiv

/* core/rtop_port.sv */
// Receive overhead serial output port
module rtop_port #(
	parameter int unsigned BYTE_W = rtop_pkg::BYTE_W
) (
	// System side clock and reset
	input  wire logic              sys_clk_in,
	input  wire logic              resetn_in,
	// Link clock of the serial port
	input  wire logic              link_clk_in,
	// Overhead bytes from the receive framer
	input  wire rtop_pkg::rtop_byte_t toh_in,
	input  wire logic              toh_valid_in,
	output logic                   toh_ready_out,
	// Serial port pins
	output logic                   overhead_port_clock_out,
	output logic                   overhead_serial_out,
	output logic                   overhead_bit_valid,
	output logic                   overhead_frame_marker
);
	import rtop_pkg::*;

	localparam int FRAME_LINK_CYC = A1_MARK_BITS * PORT_DIV;
	localparam int BYTE_LINK_CYC  = BYTE_W * PORT_DIV;

	// Shared by the load and the per-bit step
	function automatic logic [BYTE_W-1:0] shift_up(
		input logic [BYTE_W-1:0] v
	);
		return {v[BYTE_W-2:0], 1'b0};
	endfunction : shift_up

	// System side handshake
	rtop_byte_t hold_ff;
	logic       req_tgl_ff;
	logic       ack_sync;
	logic       pending;
	logic       take;

	// Link side
	logic              link_rst_n;
	logic              req_sync;
	logic              ack_tgl_ff;
	logic              avail;
	logic              pclk;
	logic              fall_ev;
	logic              need_load;
	logic              load;
	rtop_state_t       state_ff;
	logic [BYTE_W-1:0] shift_ff;
	logic [BIT_CNT_W-1:0] bit_cnt_ff;
	logic              ser_ff;
	logic              valid_ff;
	logic              frame_ff;
	rtop_port_t        port;

	// Reset reaches the link domain through a synchroniser
	rtop_sync #(
		.RST_VAL (1'b0)
	) u_rst_sync (
		.clk_in   (link_clk_in),
		.rst_n_in (1'b1),
		.d_in     (resetn_in),
		.q_out    (link_rst_n)
	);

	rtop_sync #(
		.RST_VAL (TGL_RST)
	) u_req_sync (
		.clk_in   (link_clk_in),
		.rst_n_in (link_rst_n),
		.d_in     (req_tgl_ff),
		.q_out    (req_sync)
	);

	rtop_sync #(
		.RST_VAL (TGL_RST)
	) u_ack_sync (
		.clk_in   (sys_clk_in),
		.rst_n_in (resetn_in),
		.d_in     (ack_tgl_ff),
		.q_out    (ack_sync)
	);

	rtop_clkdiv u_div (
		.clk_in   (link_clk_in),
		.rst_n_in (link_rst_n),
		.pclk_out (pclk),
		.fall_out (fall_ev)
	);

	// One byte in flight: the source stalls until the link has it
	assign pending       = req_tgl_ff ^ ack_sync;
	assign toh_ready_out = ~pending;
	assign take          = toh_valid_in & ~pending;

	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			req_tgl_ff <= TGL_RST;
		end else if (take) begin
			req_tgl_ff <= ~req_tgl_ff;
		end
	end

	// Held stable while the request is open, so the link may read it
	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			hold_ff <= '0;
		end else if (take) begin
			hold_ff <= toh_in;
		end
	end

	// Link side load decision
	assign avail     = req_sync ^ ack_tgl_ff;
	assign need_load = (state_ff == RTOP_IDLE) || (bit_cnt_ff == '0);
	assign load      = fall_ev & need_load & avail;

	always_ff @(posedge link_clk_in) begin
		if (!link_rst_n) begin
			ack_tgl_ff <= TGL_RST;
		end else if (load) begin
			ack_tgl_ff <= ~ack_tgl_ff;
		end
	end

	// Everything below but the helper counters moves only at the falling point of the port clock
	always_ff @(posedge link_clk_in) begin
		if (!link_rst_n) begin
			state_ff <= RTOP_IDLE;
		end else if (fall_ev) begin
			case (state_ff)
				RTOP_IDLE: begin
					if (avail) begin
						state_ff <= RTOP_SHIFT;
					end
				end
				RTOP_SHIFT: begin
					if (bit_cnt_ff == '0 && !avail) begin
						state_ff <= RTOP_IDLE;
					end
				end
				default: begin
					state_ff <= RTOP_IDLE;
				end
			endcase
		end
	end

	// MSB goes first, as the bytes sit on the line
	always_ff @(posedge link_clk_in) begin
		if (!link_rst_n) begin
			shift_ff   <= '0;
			bit_cnt_ff <= BIT_CNT_RST;
			ser_ff     <= SER_RST;
		end else if (load) begin
			shift_ff   <= shift_up(hold_ff.data);
			bit_cnt_ff <= BIT_CNT_W'(BYTE_W - 1);
			ser_ff     <= hold_ff.data[BYTE_W-1];
		end else if (fall_ev && !need_load) begin
			shift_ff   <= shift_up(shift_ff);
			bit_cnt_ff <= bit_cnt_ff - 1'b1;
			ser_ff     <= shift_ff[BYTE_W-1];
		end
	end

	// Valid covers real bits only; an empty period drops it
	always_ff @(posedge link_clk_in) begin
		if (!link_rst_n) begin
			valid_ff <= VALID_RST;
		end else if (fall_ev) begin
			valid_ff <= ~need_load | avail;
		end
	end

	// Marker spans the byte flagged as A1, no more
	always_ff @(posedge link_clk_in) begin
		if (!link_rst_n) begin
			frame_ff <= FRAME_RST;
		end else if (load) begin
			frame_ff <= hold_ff.a1_start;
		end else if (fall_ev && need_load) begin
			frame_ff <= 1'b0;
		end
	end

	// Pins, gathered in one assignment so the struct has a single driver
	assign port = '{
		clk:   pclk,
		data:  ser_ff,
		valid: valid_ff,
		frame: frame_ff
	};

	// Receiver samples on the rise, half a period after each change
	assign overhead_port_clock_out = port.clk;
	assign overhead_serial_out     = port.data;
	assign overhead_bit_valid      = port.valid;
	assign overhead_frame_marker   = port.frame;

	// Helper counters for the checks
	logic [7:0] frm_len_ff;
	logic [7:0] val_len_ff;

	always_ff @(posedge link_clk_in) begin
		if (!link_rst_n) begin
			frm_len_ff <= 8'h00;
			val_len_ff <= 8'h00;
		end else begin
			frm_len_ff <= frame_ff ? frm_len_ff + 8'h01 : 8'h00;
			val_len_ff <= valid_ff ? val_len_ff + 8'h01 : 8'h00;
		end
	end

	sequence s_pclk_falls;
		pclk ##1 !pclk;
	endsequence

	sequence s_quiet_period;
		!fall_ev ##1 1'b1;
	endsequence

	a_clk_toggles: assert property (
		@(posedge link_clk_in) disable iff (!link_rst_n)
		pclk |=> !pclk
	) else $error("port clock did not toggle");

	a_clk_rises: assert property (
		@(posedge link_clk_in) disable iff (!link_rst_n)
		!pclk |=> pclk
	) else $error("port clock stuck low");

	a_data_fall_only: assert property (
		@(posedge link_clk_in) disable iff (!link_rst_n)
		s_quiet_period |-> $stable(ser_ff) && $stable(valid_ff)
			&& $stable(frame_ff)
	) else $error("port output changed off the falling edge");

	a_load_msb_first: assert property (
		@(posedge link_clk_in) disable iff (!link_rst_n)
		load |=> ser_ff == $past(hold_ff.data[BYTE_W-1]) && valid_ff
	) else $error("first bit of a byte is not its MSB");

	a_bit_order: assert property (
		@(posedge link_clk_in) disable iff (!link_rst_n)
		s_pclk_falls and (fall_ev && !need_load ##1 1'b1)
		|-> ser_ff == $past(shift_ff[BYTE_W-1])
	) else $error("serial bit out of order");

	a_idle_low: assert property (
		@(posedge link_clk_in) disable iff (!link_rst_n)
		fall_ev && need_load && !avail |=> !valid_ff && !frame_ff
	) else $error("valid or marker high with no bit");

	a_frame_eight: assert property (
		@(posedge link_clk_in) disable iff (!link_rst_n)
		$fell(frame_ff) |-> $past(frm_len_ff) == 8'(FRAME_LINK_CYC - 1)
	) else $error("frame marker not eight periods");

	a_frame_in_valid: assert property (
		@(posedge link_clk_in) disable iff (!link_rst_n)
		frame_ff |-> valid_ff && state_ff == RTOP_SHIFT
	) else $error("frame marker outside a valid byte");

	a_valid_whole: assert property (
		@(posedge link_clk_in) disable iff (!link_rst_n)
		$fell(valid_ff) |-> $past(val_len_ff) >= 8'(BYTE_LINK_CYC - 1)
	) else $error("valid dropped inside a byte");

	a_take_stalls: assert property (
		@(posedge sys_clk_in) disable iff (!resetn_in)
		take |=> !toh_ready_out [*2]
	) else $error("source not stalled after a byte was taken");

	// Worst case waits out a whole byte on the link plus both crossings
	sequence s_ready_back;
		##[3:40] toh_ready_out;
	endsequence

	sequence s_byte_loaded;
		load ##1 1'b1;
	endsequence

	// The link reads the held byte unsynchronised, so it must not move
	a_hold_stable: assert property (
		@(posedge sys_clk_in) disable iff (!resetn_in)
		pending |=> $stable(hold_ff)
	) else $error("held byte changed while in flight");

	a_ready_back: assert property (
		@(posedge sys_clk_in) disable iff (!resetn_in)
		take |-> s_ready_back
	) else $error("source stalled too long");

	a_one_load: assert property (
		@(posedge link_clk_in) disable iff (!link_rst_n)
		s_byte_loaded |-> !avail
	) else $error("one handover loaded twice");

	a_mark_on_a1: assert property (
		@(posedge link_clk_in) disable iff (!link_rst_n)
		$rose(frame_ff) |-> $past(load && hold_ff.a1_start)
	) else $error("frame marker rose without an A1 byte");

	a_idle_no_valid: assert property (
		@(posedge link_clk_in) disable iff (!link_rst_n)
		state_ff == RTOP_IDLE |-> !valid_ff
	) else $error("valid high while the shifter is idle");

	a_valid_bytes: assert property (
		@(posedge link_clk_in) disable iff (!link_rst_n)
		$fell(valid_ff)
			|-> $past(val_len_ff) % 8'(BYTE_LINK_CYC) == 8'(BYTE_LINK_CYC - 1)
	) else $error("valid run not a whole number of bytes");

endmodule : rtop_port

/* sim/rtop_rx_model.sv */
// Receiving logic model that samples the overhead serial port
module rtop_rx_model (
	// Port pins from the block
	input  wire logic pclk_in,
	input  wire logic data_in,
	input  wire logic valid_in,
	input  wire logic frame_in,
	// Edge checks start once the pins have left reset
	input  wire logic arm_in
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [11:0] rx_q[$];
	logic [7:0]  sh;
	logic [3:0]  mk;
	int          bits     = 0;
	int          bad_clk  = 0;
	int          bad_edge = 0;
	int          bad_mark = 0;
	realtime     t_rise   = 0;
	realtime     t_fall   = 0;
	realtime     t_chg;

	// Sampling on the rise keeps half a period away from the data change
	always @(posedge pclk_in) begin
		if (t_rise > 0 && $realtime - t_rise < 128.0)
			bad_clk++;
		t_rise = $realtime;
		if (valid_in === 1'b1) begin
			if (bits == 0)
				mk = 4'h0;
			sh = {sh[6:0], data_in};
			mk = mk + {3'h0, frame_in};
			bits++;
			if (bits == 8) begin
				rx_q.push_back({sh, mk});
				bits = 0;
			end
		end else if (frame_in === 1'b1) begin
			bad_mark++;
		end
	end

	always @(negedge pclk_in) t_fall = $realtime;

	// The delay lets the falling edge be noted whatever the event order
	always @(data_in or valid_in or frame_in) begin
		t_chg = $realtime;
		#1;
		if (arm_in && t_chg != t_fall)
			bad_edge++;
	end
endmodule : rtop_rx_model

/* sim/tb.sv */
// Self-checking testbench of the receive overhead serial port
module tb;
	import rtop_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	logic        sys_clk_in   = 1'b0;
	logic        link_clk_in  = 1'b0;
	logic        resetn_in    = 1'b0;
	rtop_byte_t  toh_in       = '0;
	logic        toh_valid_in = 1'b0;
	logic        armed        = 1'b0;
	logic        toh_ready_out, pclk, ser, val, frm;
	int          num_errors   = 0;
	int          n_checks     = 0;
	int          cycles       = 0;
	logic [11:0] exp_q[$];

	always #25 sys_clk_in = ~sys_clk_in;
	initial #7 forever #32 link_clk_in = ~link_clk_in;

	rtop_port i_dut (
		.sys_clk_in              (sys_clk_in),
		.resetn_in               (resetn_in),
		.link_clk_in             (link_clk_in),
		.toh_in                  (toh_in),
		.toh_valid_in            (toh_valid_in),
		.toh_ready_out           (toh_ready_out),
		.overhead_port_clock_out (pclk),
		.overhead_serial_out     (ser),
		.overhead_bit_valid      (val),
		.overhead_frame_marker   (frm)
	);

	rtop_rx_model i_rx (
		.pclk_in  (pclk),
		.data_in  (ser),
		.valid_in (val),
		.frame_in (frm),
		.arm_in   (armed)
	);

	task automatic check(input string what, input logic [11:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic complete_run();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : complete_run

	// Hands one byte over; entered 1 ns after a system clock edge
	task automatic send(input logic [7:0] d, input logic a1);
		while (toh_ready_out !== 1'b1) begin
			@(posedge sys_clk_in);
			#1;
		end
		toh_in = '{data: d, a1_start: a1};
		toh_valid_in = 1'b1;
		@(posedge sys_clk_in);
		#1;
		toh_valid_in = 1'b0;
		check("ready after take", {11'h0, toh_ready_out}, 12'h0);
		exp_q.push_back({d, a1 ? 4'h8 : 4'h0});
	endtask : send

	task automatic drain();
		int n;
		n = 0;
		while (i_rx.rx_q.size() < exp_q.size() && n < 2000) begin
			@(posedge sys_clk_in);
			#1;
			n++;
		end
		check("drain wait", {11'h0, n < 2000}, 12'h1);
		while (exp_q.size() > 0)
			check("byte", i_rx.rx_q.pop_front(), exp_q.pop_front());
		check("extra bytes", 12'(i_rx.rx_q.size()), 12'h0);
	endtask : drain

	// A frame start followed by bytes handed over back to back
	task automatic t_frame();
		logic [7:0] v[6] = '{8'hf6, 8'hf6, 8'h28, 8'h01, 8'h5a, 8'hc3};
		foreach (v[i])
			send(v[i], i == 0);
		drain();
	endtask : t_frame

	// Lone bytes with idle gaps, the marker on the second and the last byte
	task automatic t_gaps();
		logic [8:0] v[4] = '{9'h000, 9'h1ff, 9'h100, 9'h003};
		foreach (v[i]) begin
			send(v[i][8:1], v[i][0]);
			drain();
			repeat (12) @(posedge sys_clk_in);
			#1;
			check("idle valid", {11'h0, val}, 12'h0);
			check("stray bits", 12'(i_rx.bits), 12'h0);
		end
	endtask : t_gaps

	always @(posedge sys_clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			complete_run();
		end
	end

	initial begin
		// Four cycles still give the link side three reset edges
		repeat (4) @(posedge sys_clk_in);
		#1;
		resetn_in = 1'b1;
		repeat (10) @(posedge sys_clk_in);
		#1;
		armed = 1'b1;
		check("ready after reset", {11'h0, toh_ready_out}, 12'h1);
		check("pins after reset", {10'h0, val, frm}, 12'h0);
		t_frame();
		t_gaps();
		check("clock period", 12'(i_rx.bad_clk), 12'h0);
		check("data edge", 12'(i_rx.bad_edge), 12'h0);
		check("idle marker", 12'(i_rx.bad_mark), 12'h0);
		complete_run();
	end
endmodule : tb
